// ### rtl/ufw_pkg.sv
// constants and state types for the upstream forwarding window control
// assumes a 32-bit Avalon-MM register port with byte addresses
package ufw_pkg;

  // =====================================================
  // register map
  localparam int unsigned UFW_ADDR_W = 8;
  localparam logic [7:0] UFW_CTRL_OFS = 8'h68;
  localparam logic [7:0] UFW_STAT_OFS = 8'h6C;
  localparam logic [31:0] UFW_RDATA_ZERO = 32'h0000_0000;

  // =====================================================
  // control register fields
  localparam int unsigned UFW_PSIZE_LSB = 16;
  localparam int unsigned UFW_PSIZE_W = 4;
  localparam int unsigned UFW_COARSE_BIT = 20;
  localparam int unsigned UFW_EN64_BIT = 21;
  localparam int unsigned UFW_FIELD_LANE = 2;
  localparam int unsigned UFW_LANE_W = 8;
  localparam logic [3:0] UFW_PSIZE_RST = 4'h0;
  localparam logic UFW_COARSE_RST = 1'b0;
  localparam logic UFW_EN64_RST = 1'b0;

  // =====================================================
  // status register fields
  localparam int unsigned UFW_STAT_LOG2_LSB = 0;
  localparam int unsigned UFW_STAT_EN_BIT = 8;

  // =====================================================
  // page size decode
  localparam logic [3:0] UFW_PSIZE_OFF = 4'h0;
  localparam logic [3:0] UFW_COARSE_MAX = 4'h3;
  localparam logic [4:0] UFW_FINE_ADJ = 5'h07;
  localparam logic [4:0] UFW_COARSE_ADJ = 5'h16;
  localparam logic [31:0] UFW_ONE = 32'h0000_0001;

  typedef enum logic [0:0] {
    UFW_BUS_IDLE = 1'b0,
    UFW_BUS_ACK = 1'b1
  } ufw_bus_t;

  typedef struct packed {
    ufw_bus_t bus;
    logic [31:0] rdata;
    logic [3:0] psize;
    logic coarse;
    logic en64;
    logic fwd_valid;
    logic fwd;
    logic xlat;
  } ufw_state_t;

endpackage : ufw_pkg

// ### rtl/ufw_window_decode.sv
// page size decode for the second upstream memory window
// assumes the page size and coarse bit come straight from registers
`timescale 1ns/10ps
`default_nettype none
module ufw_window_decode (
  input wire logic [3:0] page_size,
  input wire logic coarse,
  output logic win_en,
  output logic [4:0] size_log2,
  output logic [31:0] win_mask
);
  import ufw_pkg::*;

  // =====================================================
  // decode
  always_comb begin
    win_en = 1'b0;
    size_log2 = 5'h00;
    if (!coarse) begin
      if (page_size != UFW_PSIZE_OFF) begin
        win_en = 1'b1;
        size_log2 = {1'b0, page_size} + UFW_FINE_ADJ;
      end
    end else begin
      if (page_size != UFW_PSIZE_OFF && page_size <= UFW_COARSE_MAX) begin
        win_en = 1'b1;
        size_log2 = {1'b0, page_size} + UFW_COARSE_ADJ;
      end
    end
    win_mask = (UFW_ONE << size_log2) - UFW_ONE;
  end

endmodule : ufw_window_decode
`default_nettype wire

// ### rtl/ufw_fwd_decide.sv
// upstream forwarding decision for one secondary-side transaction
// assumes range hit flags are produced by the base address logic
`timescale 1ns/10ps
`default_nettype none
module ufw_fwd_decide (
  input wire logic is64,
  input wire logic [31:0] addr_lo,
  input wire logic en64,
  input wire logic dn3_hit,
  input wire logic up3_hit,
  input wire logic win_en,
  input wire logic [31:0] win_mask,
  input wire logic [31:0] up2_base,
  output logic fwd,
  output logic xlat
);
  import ufw_pkg::*;

  // =====================================================
  // decision
  always_comb begin
    fwd = 1'b0;
    xlat = 1'b0;
    if (is64) begin
      if (en64) begin
        fwd = up3_hit;
      end else begin
        fwd = !dn3_hit;
      end
    end else begin
      fwd = win_en && ((addr_lo & ~win_mask) == (up2_base & ~win_mask));
      xlat = fwd;
    end
  end

endmodule : ufw_fwd_decide
`default_nettype wire

// ### rtl/ufw_ctrl.sv
// memory forwarding control register, window decode and forward decision
// assumes Avalon-MM master holds requests until waitrequest is low
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - fine mode: code zero disables window two; codes one up double from 256 bytes.
// - coarse mode: zero disables; one, two, three give 8M, 16M, 32M bytes.
// - coarse mode codes four and above disable window two.
// - 64-bit enable clear: forward 64-bit transactions outside downstream range three.
// - 64-bit enable set: forward only inside upstream range three, untranslated.
// - bits 26 to 22 read zero and ignore writes.
// - 64-bit enable is writable bit 21, reset to zero.
// - page size resets to zero, window two starts disabled.
module ufw_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic txn_valid,
  input wire logic txn_is64,
  input wire logic [31:0] txn_addr_lo,
  input wire logic txn_dn3_hit,
  input wire logic txn_up3_hit,
  input wire logic [31:0] up2_base,
  output logic fwd_valid,
  output logic fwd_upstream,
  output logic fwd_translate,
  output logic up2_win_en,
  output logic [31:0] up2_win_mask
);
  import ufw_pkg::*;

  ufw_state_t s_q;
  ufw_state_t s_d;
  logic win_en;
  logic [4:0] size_log2;
  logic [31:0] win_mask;
  logic fwd;
  logic xlat;

  function automatic logic [31:0] ctrl_word(input logic [3:0] psize, input logic coarse,
                                            input logic en64);
    logic [31:0] w;
    w = UFW_RDATA_ZERO;
    w[UFW_PSIZE_LSB +: UFW_PSIZE_W] = psize;
    w[UFW_COARSE_BIT] = coarse;
    w[UFW_EN64_BIT] = en64;
    return w;
  endfunction : ctrl_word

  // =====================================================
  // decode and decision
  ufw_window_decode u_win (
    .page_size(s_q.psize),
    .coarse(s_q.coarse),
    .win_en(win_en),
    .size_log2(size_log2),
    .win_mask(win_mask)
  );

  ufw_fwd_decide u_fwd (
    .is64(txn_is64),
    .addr_lo(txn_addr_lo),
    .en64(s_q.en64),
    .dn3_hit(txn_dn3_hit),
    .up3_hit(txn_up3_hit),
    .win_en(win_en),
    .win_mask(win_mask),
    .up2_base(up2_base),
    .fwd(fwd),
    .xlat(xlat)
  );

  // =====================================================
  // next state
  always_comb begin
    logic [31:0] stat;
    logic [7:0] lane;
    stat = UFW_RDATA_ZERO;
    stat[UFW_STAT_LOG2_LSB +: $bits(size_log2)] = size_log2;
    stat[UFW_STAT_EN_BIT] = win_en;
    lane = avs_writedata[UFW_FIELD_LANE*UFW_LANE_W +: UFW_LANE_W];
    s_d = s_q;
    s_d.fwd_valid = txn_valid;
    s_d.fwd = txn_valid && fwd;
    s_d.xlat = txn_valid && xlat;
    case (s_q.bus)
      UFW_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.bus = UFW_BUS_ACK;
          if (avs_read) begin
            if (avs_address == UFW_CTRL_OFS) begin
              s_d.rdata = ctrl_word(s_q.psize, s_q.coarse, s_q.en64);
            end else if (avs_address == UFW_STAT_OFS) begin
              s_d.rdata = stat;
            end else begin
              s_d.rdata = UFW_RDATA_ZERO;
            end
          end
        end
      end
      UFW_BUS_ACK: begin
        s_d.bus = UFW_BUS_IDLE;
        if (avs_write && avs_address == UFW_CTRL_OFS && avs_byteenable[UFW_FIELD_LANE]) begin
          s_d.psize = lane[UFW_PSIZE_LSB-UFW_FIELD_LANE*UFW_LANE_W +: UFW_PSIZE_W];
          s_d.coarse = lane[UFW_COARSE_BIT-UFW_FIELD_LANE*UFW_LANE_W];
          s_d.en64 = lane[UFW_EN64_BIT-UFW_FIELD_LANE*UFW_LANE_W];
        end
      end
      default: begin
        s_d.bus = UFW_BUS_IDLE;
      end
    endcase
  end

  // =====================================================
  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q.bus <= UFW_BUS_IDLE;
      s_q.rdata <= UFW_RDATA_ZERO;
      s_q.psize <= UFW_PSIZE_RST;
      s_q.coarse <= UFW_COARSE_RST;
      s_q.en64 <= UFW_EN64_RST;
      s_q.fwd_valid <= 1'b0;
      s_q.fwd <= 1'b0;
      s_q.xlat <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs
  assign avs_waitrequest = (avs_read || avs_write) && (s_q.bus == UFW_BUS_IDLE);
  assign avs_readdata = s_q.rdata;
  assign fwd_valid = s_q.fwd_valid;
  assign fwd_upstream = s_q.fwd;
  assign fwd_translate = s_q.xlat;
  assign up2_win_en = win_en;
  assign up2_win_mask = win_mask;

endmodule : ufw_ctrl
`default_nettype wire

// ### tb/ufw_ctrl_properties.sv
// port assertions for ufw_ctrl
// assumes a bind from the bench top file
`timescale 1ns/10ps
`default_nettype none
module ufw_ctrl_properties (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic txn_valid,
  input wire logic txn_is64,
  input wire logic fwd_valid,
  input wire logic fwd_upstream,
  input wire logic fwd_translate,
  input wire logic up2_win_en,
  input wire logic [31:0] up2_win_mask
);
  // =========================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  AST_FOLLOW: assert property (fwd_valid == $past(txn_valid)) else $error("valid lag");
  AST_IDLE: assert property (!fwd_valid |-> !fwd_upstream && !fwd_translate)
    else $error("idle forward");
  AST_XLAT: assert property (fwd_translate |-> fwd_upstream) else $error("lone translate");
  AST_NO64: assert property (txn_valid && txn_is64 |=> !fwd_translate)
    else $error("64-bit translated");
  AST_OFF: assert property (!up2_win_en |-> up2_win_mask == 32'h0000_0000)
    else $error("mask while off");
  AST_SHAPE: assert property (up2_win_en |-> ((up2_win_mask + 1) & up2_win_mask) == 0
    && up2_win_mask inside {[32'h0000_00FF:32'h01FF_FFFF]}) else $error("bad mask");
  AST_RSVD: assert property (avs_read && !avs_waitrequest |-> avs_readdata[26:22] == 5'h00)
    else $error("reserved set");
  AST_HOLD: assert property (!(avs_write && !avs_waitrequest) |=> $stable(up2_win_mask))
    else $error("mask moved");
endmodule : ufw_ctrl_properties
`default_nettype wire

// ### tb/ufw_ctrl_tb.sv
// self-checking bench for ufw_ctrl
// assumes the rtl package and modules compile first
`timescale 1ns/10ps
`default_nettype none
module ufw_ctrl_tb;
  import ufw_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, txn_addr_lo = 32'h0000_0000;
  logic [31:0] up2_base = 32'h0000_0000, avs_readdata, up2_win_mask, d, x_mask;
  logic [3:0] avs_byteenable = 4'h0;
  logic txn_valid = 1'b0, txn_is64 = 1'b0, txn_dn3_hit = 1'b0, txn_up3_hit = 1'b0;
  logic avs_waitrequest, fwd_valid, fwd_upstream, fwd_translate, up2_win_en, x_en, x_en64;
  logic [4:0] lg;
  logic [31:0] rd_q[$];
  logic [1:0] fw_q[$];
  int fail_count = 0, check_count = 0, cyc = 0, i;
  ufw_ctrl ufw_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .txn_valid(txn_valid), .txn_is64(txn_is64),
    .txn_addr_lo(txn_addr_lo), .txn_dn3_hit(txn_dn3_hit), .txn_up3_hit(txn_up3_hit),
    .up2_base(up2_base), .fwd_valid(fwd_valid), .fwd_upstream(fwd_upstream),
    .fwd_translate(fwd_translate), .up2_win_en(up2_win_en), .up2_win_mask(up2_win_mask));
  // =========================
  // tasks
  task tally_and_finish;
    begin
      if (rd_q.size() != 0 || fw_q.size() != 0) begin
        fail_count++;
        $display("mismatch at %0t: %0d results never appeared", $time, rd_q.size() + fw_q.size());
      end
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        fail_count++;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] w, input logic [3:0] be);
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= w;
      avs_byteenable <= be;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
    end
  endtask : rd
  // holds valid high; the caller lowers it
  task txn(input logic is64);
    logic [31:0] r, a;
    logic dn, up, m;
    begin
      r = $urandom;
      a = r[31] ? up2_base ^ (r & x_mask) : r;
      dn = r[0];
      up = r[1];
      m = x_en && ((a & ~x_mask) == (up2_base & ~x_mask));
      fw_q.push_back({is64 ? (x_en64 ? up : !dn) : m, !is64 && m});
      txn_valid <= 1'b1;
      txn_is64 <= is64;
      txn_addr_lo <= a;
      txn_dn3_hit <= dn;
      txn_up3_hit <= up;
      @(posedge clk_sys);
    end
  endtask : txn
  // =========================
  // clock, monitor, timeout
  initial forever #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, rd_q.pop_front());
    if (fwd_valid === 1'b1) chk({fwd_upstream, fwd_translate}, fw_q.pop_front());
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // =========================
  // main sequence
  initial begin
    void'($urandom(8816));
    up2_base <= $urandom;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(UFW_CTRL_OFS, 32'h0000_0000);
    for (i = 0; i < 64; i++) begin
      x_en64 = i[5];
      if (!i[4]) lg = (i[3:0] == 4'h0) ? 5'h00 : {1'b0, i[3:0]} + 5'h07;
      else lg = (i[3:0] inside {[4'h1:4'h3]}) ? {1'b0, i[3:0]} + 5'h16 : 5'h00;
      x_en = lg != 5'h00;
      x_mask = x_en ? (32'h0000_0001 << lg) - 1 : 32'h0000_0000;
      d = $urandom;
      d[21:16] = i[5:0];
      bus(1'b1, UFW_CTRL_OFS, d, 4'hF);
      txn(1'b0);
      txn(1'b1);
      txn_valid <= 1'b0;
      @(negedge clk_sys);
      chk(up2_win_mask, x_mask);
      chk({31'h0, up2_win_en}, {31'h0, x_en});
      rd(UFW_CTRL_OFS, d & 32'h003F_0000);
      rd(UFW_STAT_OFS, {23'h0, x_en, 3'h0, lg});
    end
    bus(1'b1, UFW_CTRL_OFS, 32'h0000_0000, 4'hB);
    rd(UFW_CTRL_OFS, 32'h003F_0000);
    rd(8'h70, 32'h0000_0000);
    // live fine window, then a mid-run reset must clear it
    bus(1'b1, UFW_CTRL_OFS, 32'h0001_0000, 4'h4);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    chk({31'h0, up2_win_en}, 32'h0000_0000);
    rd(UFW_CTRL_OFS, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : ufw_ctrl_tb
bind ufw_ctrl ufw_ctrl_properties ufw_ctrl_properties_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .txn_valid(txn_valid), .txn_is64(txn_is64),
  .fwd_valid(fwd_valid), .fwd_upstream(fwd_upstream), .fwd_translate(fwd_translate),
  .up2_win_en(up2_win_en), .up2_win_mask(up2_win_mask));
`default_nettype wire
